// ===== verilog/strap_status_regs.svh
// Purpose: offsets, field positions, reset values and counts for the strap/status block
// Assumes: byte-wide register port, 7-bit target address
// Notes:   definitions only
`ifndef STRAP_STATUS_REGS_SVH
`define STRAP_STATUS_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define STATUS_OFS        8'h10
`define MASK_OFS          8'h11
`define SWITCH_CURRENT_LIMIT_OFS          8'h12
`define COMP_OFS          8'h13

// ****************************************
// field positions and reset values
// ****************************************
`define BIT_POWER_GOOD    4
`define BIT_OVER_VOLTAGE  3
`define BIT_OUTPUT_SHORT  2
`define BIT_THERMAL       1
`define BIT_OVER_CURRENT  0
`define MASK_RESET        8'h0f
`define COMP_RESET        3'h0

// ****************************************
// strap decode constants
// ****************************************
`define ADDR_BASE         7'h66
`define STRAP_EXT_FIRST   5'h10

// ****************************************
// latch-off timer
// ****************************************
`define CLK_PERIOD_NS     4
`define LATCH_TIME_US     427
`define LATCH_CYCLES      ((`LATCH_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== verilog/strap_status_pkg.sv
// Purpose: types shared by the strap/status block
// Assumes: nothing beyond the header
// Notes:   current limit codes follow the three-bit field
package strap_status_pkg;

   typedef enum logic [2:0] {
      SWITCH_CURRENT_LIMIT_7A0  = 3'h0,
      SWITCH_CURRENT_LIMIT_6A2  = 3'h1,
      SWITCH_CURRENT_LIMIT_5A6  = 3'h2,
      SWITCH_CURRENT_LIMIT_4A6  = 3'h3,
      SWITCH_CURRENT_LIMIT_3A8  = 3'h4,
      SWITCH_CURRENT_LIMIT_2A8  = 3'h5,
      SWITCH_CURRENT_LIMIT_1A8  = 3'h6,
      SWITCH_CURRENT_LIMIT_0A99 = 3'h7
   } current_limit_t;

   typedef enum logic [1:0] {
      RUN_OFF      = 2'h0,
      RUN_ON       = 2'h1,
      RUN_LATCHED  = 2'h2
   } run_state_t;

endpackage

// ===== verilog/strap_status.sv
// Purpose: strap decode, power-good, sticky faults, mask and alert pin
// Assumes: comparator and strap inputs arrive asynchronous to mclk_i
// Notes:   registers reached over a simple byte port behind the serial slave
`timescale 1ns/1ns
`include "strap_status_regs.svh"

module strap_status (
   input  wire logic                             mclk_i,
   input  wire logic                             sys_rst_i,
   input  wire logic                             supply_ok_i,
   input  wire logic                             logic_rail_ok_i,
   input  wire logic                             enable_i,
   input  wire logic [4:0]                       strap_resistor_i,
   input  wire logic                             vout_above_95_i,
   input  wire logic                             vout_below_85_i,
   input  wire logic                             ramp_active_i,
   input  wire logic                             ovp_trip_i,
   input  wire logic                             ovp_release_i,
   input  wire logic                             over_current_i,
   input  wire logic                             short_state_i,
   input  wire logic                             thermal_trip_i,
   input  wire logic [7:0]                       reg_addr_i,
   input  wire logic                             reg_wr_i,
   input  wire logic [7:0]                       reg_wdata_i,
   output logic      [7:0]                       reg_rdata_o,
   output logic      [6:0]                       target_address_o,
   output logic                                  ext_feedback_o,
   output strap_status_pkg::current_limit_t      switch_current_limit_o,
   output logic      [2:0]                       comp_setting_o,
   output logic                                  regulator_on_o,
   output logic                                  clamp_high_off_o,
   output logic                                  clamp_low_on_o,
   output logic                                  discharge_o,
   output logic                                  status_alert_pin_o,
   output logic                                  status_alert_pin_oe_o
);
   import strap_status_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   // agree stage passes a level only once two samples match, so one-cycle glitches die
   localparam int NS = 11;
   logic [NS-1:0] s1_q, s2_q, s3_q, clean_q;
   wire  [NS-1:0] raw = {supply_ok_i, logic_rail_ok_i, enable_i, vout_above_95_i,
                         vout_below_85_i, ramp_active_i, ovp_trip_i, ovp_release_i,
                         over_current_i, short_state_i, thermal_trip_i};
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge mclk_i) begin
            s1_q[gi] <= sys_rst_i ? 1'b0 : raw[gi];
            s2_q[gi] <= sys_rst_i ? 1'b0 : s1_q[gi];
            s3_q[gi] <= sys_rst_i ? 1'b0 : s2_q[gi];
            if (sys_rst_i)
               clean_q[gi] <= 1'b0;
            else if (s2_q[gi] == s3_q[gi])
               clean_q[gi] <= s3_q[gi];
         end
      end
   endgenerate

   // strap pins are static; three stages still guard against a slow settle
   logic [4:0] st1_q, st2_q, st3_q;
   always_ff @(posedge mclk_i) begin
      st1_q <= strap_resistor_i;
      st2_q <= st1_q;
      st3_q <= st2_q;
   end

   wire supply_ok  = clean_q[10];
   wire rail_ok    = clean_q[9];
   wire en         = clean_q[8];
   wire above_95   = clean_q[7];
   wire below_85   = clean_q[6];
   wire ramp       = clean_q[5];
   wire ovp_trip   = clean_q[4];
   wire ovp_rel    = clean_q[3];
   wire oc         = clean_q[2];
   wire short_st   = clean_q[1];
   wire therm      = clean_q[0];

   // ****************************************
   // power domain reset
   // ****************************************
   wire lockout = sys_rst_i | ~supply_ok | ~rail_ok;

   // ****************************************
   // strap capture and decode
   // ****************************************
   logic       strap_done_q;
   logic [4:0] strap_q;
   always_ff @(posedge mclk_i) begin
      if (lockout) begin
         strap_done_q <= 1'b0;
         strap_q      <= 5'h00;
      end else if (!strap_done_q && st2_q == st3_q) begin
         strap_done_q <= 1'b1;
         strap_q      <= st3_q;
      end
   end

   wire [6:0] strap_addr = `ADDR_BASE | {3'h0, strap_q[1], 2'h0, strap_q[0]};
   wire       strap_ext  = strap_q >= `STRAP_EXT_FIRST;
   current_limit_t strap_switch_current_limit;
   always_comb begin
      unique case (strap_q[3:2])
         2'h0: strap_switch_current_limit = SWITCH_CURRENT_LIMIT_7A0;
         2'h1: strap_switch_current_limit = SWITCH_CURRENT_LIMIT_5A6;
         2'h2: strap_switch_current_limit = SWITCH_CURRENT_LIMIT_3A8;
         2'h3: strap_switch_current_limit = SWITCH_CURRENT_LIMIT_1A8;
      endcase
   end

   // ****************************************
   // register port
   // ****************************************
   logic [7:0]     mask_q;
   logic [2:0]     comp_q;
   logic           switch_current_limit_wr_q;
   current_limit_t switch_current_limit_q;
   wire wr_mask = reg_wr_i && reg_addr_i == `MASK_OFS;
   wire wr_switch_current_limit = reg_wr_i && reg_addr_i == `SWITCH_CURRENT_LIMIT_OFS;
   wire wr_comp = reg_wr_i && reg_addr_i == `COMP_OFS;

   always_ff @(posedge mclk_i) begin
      if (lockout) begin
         mask_q    <= `MASK_RESET;
         comp_q    <= `COMP_RESET;
         switch_current_limit_wr_q <= 1'b0;
         switch_current_limit_q    <= SWITCH_CURRENT_LIMIT_7A0;
      end else begin
         if (wr_mask)
            mask_q <= {3'h0, reg_wdata_i[4:0]};
         if (wr_comp)
            comp_q <= reg_wdata_i[2:0];
         if (wr_switch_current_limit) begin
            switch_current_limit_wr_q <= 1'b1;
            switch_current_limit_q    <= current_limit_t'(reg_wdata_i[2:0]);
         end
      end
   end

   // ****************************************
   // run state, faults, power-good
   // ****************************************
   run_state_t run_q;
   logic [3:0] fault_q;
   logic       pgood_q;
   logic       clamp_q;
   logic [31:0] ocp_cnt_q;
   logic        en_prev_q;

   wire en_fall   = en_prev_q & ~en;
   wire ocp_latch = run_q == RUN_ON && oc && ocp_cnt_q == 32'(`LATCH_CYCLES - 1);
   wire th_latch  = run_q == RUN_ON && therm;

   always_ff @(posedge mclk_i) begin
      if (lockout) begin
         en_prev_q <= 1'b0;
         ocp_cnt_q <= 32'h0;
      end else begin
         en_prev_q <= en;
         ocp_cnt_q <= (run_q == RUN_ON && oc) ? ocp_cnt_q + 32'h1 : 32'h0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (lockout) begin
         run_q   <= RUN_OFF;
         fault_q <= 4'h0;
         pgood_q <= 1'b0;
         clamp_q <= 1'b0;
      end else begin
         // enable falling is the power cycle that drops sticky faults
         if (en_fall)
            fault_q <= 4'h0;
         // later bit writes win, so an event in the clearing cycle is kept
         if (ovp_trip && run_q == RUN_ON)
            fault_q[`BIT_OVER_VOLTAGE] <= 1'b1;
         if (ocp_latch) begin
            fault_q[`BIT_OVER_CURRENT] <= 1'b1;
            if (short_st)
               fault_q[`BIT_OUTPUT_SHORT] <= 1'b1;
         end
         if (th_latch)
            fault_q[`BIT_THERMAL] <= 1'b1;
         if (ovp_trip && run_q == RUN_ON)
            clamp_q <= 1'b1;
         else if (ovp_rel || run_q != RUN_ON)
            clamp_q <= 1'b0;
         unique case (run_q)
            RUN_OFF: begin
               if (en)
                  run_q <= RUN_ON;
            end
            RUN_ON: begin
               if (!en)
                  run_q <= RUN_OFF;
               else if (ocp_latch || th_latch)
                  run_q <= RUN_LATCHED;
            end
            RUN_LATCHED: begin
               if (!en)
                  run_q <= RUN_OFF;
            end
            default: run_q <= RUN_OFF;
         endcase
         if (run_q == RUN_ON && !ramp) begin
            if (below_85)
               pgood_q <= 1'b0;
            else if (above_95)
               pgood_q <= 1'b1;
         end
      end
   end

   wire [7:0] status = {3'h0, pgood_q, fault_q};
   wire       alert  = |(status & ~mask_q);

   // ****************************************
   // outputs
   // ****************************************
   logic thermal_latched_q;
   always_ff @(posedge mclk_i) begin
      if (lockout)
         thermal_latched_q <= 1'b0;
      else if (th_latch)
         thermal_latched_q <= 1'b1;
      else if (en_fall)
         thermal_latched_q <= 1'b0;
   end

   always_comb begin
      unique case (reg_addr_i)
         `STATUS_OFS: reg_rdata_o = status;
         `MASK_OFS:   reg_rdata_o = mask_q;
         `SWITCH_CURRENT_LIMIT_OFS:   reg_rdata_o = {5'h0, switch_current_limit_o};
         `COMP_OFS:   reg_rdata_o = {5'h0, comp_q};
         default:     reg_rdata_o = 8'h00;
      endcase
   end

   assign target_address_o       = strap_addr;
   assign ext_feedback_o         = strap_ext;
   assign switch_current_limit_o = switch_current_limit_wr_q ? switch_current_limit_q : strap_switch_current_limit;
   assign comp_setting_o         = comp_q;
   assign regulator_on_o         = run_q == RUN_ON && !lockout;
   assign clamp_high_off_o       = clamp_q;
   assign clamp_low_on_o         = clamp_q;
   // discharge on latch-off except thermal
   assign discharge_o            = run_q == RUN_LATCHED && !thermal_latched_q;
   assign status_alert_pin_o     = 1'b0;
   assign status_alert_pin_oe_o  = alert;

   // ****************************************
   // assertions
   // ****************************************
   alert_drive_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      status_alert_pin_oe_o == |({3'h0, pgood_q, fault_q} & ~mask_q))
      else $error("alert enable disagrees with unmasked flags");
   fault_sticky_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (fault_q != 4'h0 && !en_fall) |=> ($past(fault_q) & ~fault_q) == 4'h0)
      else $error("fault flag dropped without power cycle");
   pgood_freeze_a: assert property (@(posedge mclk_i) disable iff (lockout)
      ramp |=> pgood_q == $past(pgood_q))
      else $error("power good moved during ramp");
   pgood_clear_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (run_q == RUN_ON && !ramp && below_85) |=> !pgood_q)
      else $error("power good not cleared below 85 percent");
   switch_current_limit_priority_a: assert property (@(posedge mclk_i) disable iff (lockout)
      wr_switch_current_limit |=> switch_current_limit_o == current_limit_t'($past(reg_wdata_i[2:0])))
      else $error("bus current limit not applied");
   short_pair_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (ocp_latch && short_st && !en_fall) |=> fault_q[2] && fault_q[0])
      else $error("short latch-off flags missing");
   lockout_reset_a: assert property (@(posedge mclk_i)
      lockout |=> mask_q == `MASK_RESET && fault_q == 4'h0 && !regulator_on_o)
      else $error("lockout did not reset registers");
   ovp_clamp_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (ovp_trip && run_q == RUN_ON) |=> clamp_q && fault_q[3] ##0 clamp_low_on_o)
      else $error("over-voltage clamp not engaged");

   // ****************************************
   // assertions: strap, register port, power-good, clamp, latch-off
   // ****************************************
   strap_capture_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (!strap_done_q && st2_q == st3_q) |=> strap_done_q && strap_q == $past(st3_q))
      else $error("strap code not captured");
   strap_hold_a: assert property (@(posedge mclk_i) disable iff (lockout)
      strap_done_q |=> $stable(strap_q))
      else $error("strap code moved after capture");
   addr_decode_a: assert property (@(posedge mclk_i) disable iff (lockout)
      strap_done_q |-> target_address_o[6:4] == 3'h6 && target_address_o[2:1] == 2'h3)
      else $error("target address outside its four values");
   ext_select_a: assert property (@(posedge mclk_i) disable iff (lockout)
      strap_done_q |-> ext_feedback_o == (strap_q > 5'h0f))
      else $error("feedback source disagrees with strap code");
   mask_write_a: assert property (@(posedge mclk_i) disable iff (lockout)
      wr_mask |=> mask_q == {3'h0, $past(reg_wdata_i[4:0])})
      else $error("mask write not applied");
   comp_write_a: assert property (@(posedge mclk_i) disable iff (lockout)
      wr_comp |=> comp_setting_o == $past(reg_wdata_i[2:0]))
      else $error("compensation write not applied");
   pgood_set_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (run_q == RUN_ON && !ramp && above_95 && !below_85) |=> pgood_q)
      else $error("power good not set above 95 percent");
   pgood_idle_a: assert property (@(posedge mclk_i) disable iff (lockout)
      run_q != RUN_ON |=> $stable(pgood_q))
      else $error("power good moved while not running");
   clamp_release_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (ovp_rel && !ovp_trip) |=> !clamp_q)
      else $error("over-voltage clamp not released");
   thermal_latch_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (th_latch && en) |=> run_q == RUN_LATCHED && fault_q[`BIT_THERMAL] && !discharge_o)
      else $error("thermal trip did not latch off cleanly");
   latch_hold_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (run_q == RUN_LATCHED && en) |=> run_q == RUN_LATCHED)
      else $error("latch-off left while enabled");
   fault_clear_a: assert property (@(posedge mclk_i) disable iff (lockout)
      (en_fall && !ovp_trip && !ocp_latch && !th_latch) |=> fault_q == 4'h0)
      else $error("enable power cycle did not clear faults");

endmodule

// ===== bench/host_model.sv
// Purpose: host side of the register port plus pull-up on the alert line
// Assumes: byte register port, combinational read data
// Notes:   changes signals 1 ns after a rising edge
`timescale 1ns/1ns
module host_model (
   input  wire logic       mclk_i,
   input  wire logic       pin_i,
   input  wire logic       pin_oe_i,
   input  wire logic [7:0] rdata_i,
   output logic            alert_level_o,
   output logic [7:0]      addr_o,
   output logic            wr_o,
   output logic [7:0]      wdata_o
);
   // pull-up resistor: line is high unless the pin sinks it
   assign alert_level_o = pin_oe_i ? pin_i : 1'b1;
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
   end
   // host only ever writes the advised mask values or test patterns
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge mclk_i);
      #1;
      wr_o = 1'b0;
      wdata_o = ~d; // stale data not left on the port
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      #1;
      addr_o = a;
      @(posedge mclk_i);
      d = rdata_i;
      #1;
   endtask
endmodule

// ===== bench/strap_status_tb.sv
// Purpose: self-checking bench for strap decode, status, mask and alert
// Assumes: async inputs settle through the filters within 12 cycles
// Notes:   latch-off timer path too long for this run, left to design checks
`timescale 1ns/1ns
`include "strap_status_regs.svh"
module strap_status_tb;
   import strap_status_pkg::*;
   logic clk, rst, sup, rail, en, hi95, lo85, ramp, ovt, ovr, th, alert, oe, wr, ro, cho, clo, dis;
   logic pin, oc, sst;
   logic [4:0] strap;
   logic [7:0] addr, wdata, rdata, v;
   logic [6:0] taddr;
   logic [2:0] comp;
   logic       ext;
   current_limit_t lim;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   strap_status u_strap_status (.mclk_i(clk), .sys_rst_i(rst), .supply_ok_i(sup),
      .logic_rail_ok_i(rail), .enable_i(en), .strap_resistor_i(strap),
      .vout_above_95_i(hi95), .vout_below_85_i(lo85), .ramp_active_i(ramp),
      .ovp_trip_i(ovt), .ovp_release_i(ovr), .over_current_i(oc),
      .short_state_i(sst), .thermal_trip_i(th), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .target_address_o(taddr),
      .ext_feedback_o(ext), .switch_current_limit_o(lim), .comp_setting_o(comp),
      .regulator_on_o(ro), .clamp_high_off_o(cho), .clamp_low_on_o(clo),
      .discharge_o(dis), .status_alert_pin_o(pin), .status_alert_pin_oe_o(oe));
   host_model u_host_model (.mclk_i(clk), .pin_i(pin), .pin_oe_i(oe), .rdata_i(rdata),
      .alert_level_o(alert), .addr_o(addr), .wr_o(wr), .wdata_o(wdata));
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cyc_supply(input logic [4:0] c);
      sup = 1'b0;
      idle(12);
      strap = c;
      sup = 1'b1;
      idle(12);
   endtask
   task automatic finish_test();
      $display("tests %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      u_host_model.rd(`MASK_OFS, v); chk("mask", 8'h0f, v);
      u_host_model.rd(`STATUS_OFS, v); chk("status", 8'h00, v);
      u_host_model.rd(8'h20, v); chk("unmapped", 8'h00, v);
      u_host_model.rd(`COMP_OFS, v); chk("comp", 8'h00, v);
      u_host_model.wr(`STATUS_OFS, 8'hff);
      u_host_model.rd(`STATUS_OFS, v); chk("status ro", 8'h00, v);
      chk("alert idle", 8'h01, alert);
      $display("t_reset done");
   endtask
   task automatic t_strap();
      logic [4:0] codes [8];
      logic [7:0] addrs [4];
      current_limit_t lims [4];
      codes = '{5'h00, 5'h05, 5'h0a, 5'h0f, 5'h10, 5'h16, 5'h1b, 5'h1f};
      addrs = '{8'h66, 8'h67, 8'h6e, 8'h6f};
      lims = '{SWITCH_CURRENT_LIMIT_7A0, SWITCH_CURRENT_LIMIT_5A6, SWITCH_CURRENT_LIMIT_3A8, SWITCH_CURRENT_LIMIT_1A8};
      foreach (codes[i]) begin
         u_host_model.wr(`MASK_OFS, 8'h10);
         u_host_model.rd(`MASK_OFS, v);
         chk("mask wr", 8'h10, v);
         cyc_supply(codes[i]);
         chk("addr", addrs[codes[i][1:0]], taddr);
         chk("switch_current_limit", lims[codes[i][3:2]], lim);
         chk("ext fb", codes[i] >= 5'h10, ext);
         u_host_model.rd(`MASK_OFS, v); chk("mask lockout", 8'h0f, v);
      end
      strap = 5'h00;
      idle(12);
      chk("addr held", 8'h6f, taddr);
      u_host_model.wr(`SWITCH_CURRENT_LIMIT_OFS, 8'h07);
      chk("switch_current_limit bus", SWITCH_CURRENT_LIMIT_0A99, lim);
      u_host_model.rd(`SWITCH_CURRENT_LIMIT_OFS, v);
      chk("switch_current_limit reg", 8'h07, v);
      u_host_model.wr(`COMP_OFS, 8'h05);
      chk("comp out", 8'h05, comp);
      $display("t_strap done");
   endtask
   task automatic t_pgood();
      en = 1'b1;
      idle(12);
      hi95 = 1'b1;
      idle(12);
      u_host_model.rd(`STATUS_OFS, v); chk("pg set", 8'h10, v);
      chk("alert pg", 8'h00, alert);
      hi95 = 1'b0;
      idle(12);
      u_host_model.rd(`STATUS_OFS, v); chk("pg hold", 8'h10, v);
      ramp = 1'b1;
      lo85 = 1'b1;
      idle(12);
      u_host_model.rd(`STATUS_OFS, v); chk("pg frozen", 8'h10, v);
      ramp = 1'b0;
      idle(12);
      u_host_model.rd(`STATUS_OFS, v); chk("pg clear", 8'h00, v);
      chk("alert off", 8'h01, alert);
      lo85 = 1'b0;
      hi95 = 1'b1;
      idle(12);
      u_host_model.wr(`MASK_OFS, 8'h1f);
      idle(2);
      chk("alert masked", 8'h01, alert);
      $display("t_pgood done");
   endtask
   task automatic t_faults();
      u_host_model.wr(`MASK_OFS, 8'h10);
      ovt = 1'b1;
      idle(12);
      chk("clamp hi", 8'h01, cho);
      chk("clamp lo", 8'h01, clo);
      u_host_model.rd(`STATUS_OFS, v); chk("ovp flag", 8'h18, v);
      chk("alert fault", 8'h00, alert);
      ovt = 1'b0;
      ovr = 1'b1;
      idle(12);
      chk("clamp rel", 8'h00, {cho, clo});
      u_host_model.wr(`STATUS_OFS, 8'h00);
      u_host_model.rd(`STATUS_OFS, v); chk("ovp sticky", 8'h18, v);
      // overload far shorter than the latch timer must leave no flag
      oc = 1'b1;
      sst = 1'b1;
      idle(100);
      u_host_model.rd(`STATUS_OFS, v);
      chk("oc no latch", 8'h18, v);
      chk("oc still on", 8'h01, ro);
      oc = 1'b0;
      sst = 1'b0;
      idle(12);
      ovr = 1'b0;
      th = 1'b1;
      idle(12);
      chk("thermal off", 8'h00, {ro, dis});
      u_host_model.rd(`STATUS_OFS, v); chk("thermal", 8'h1a, v);
      th = 1'b0;
      en = 1'b0;
      idle(12);
      u_host_model.rd(`STATUS_OFS, v); chk("en cycle", 8'h00, v & 8'h0f);
      en = 1'b1;
      idle(12);
      sup = 1'b0;
      idle(12);
      chk("lockout off", 8'h00, ro);
      $display("t_faults done");
   endtask
   // ****************************************
   // main
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         $display("ERROR timeout expected done seen hang");
         finish_test();
      end
   end
   initial begin
      {rst, sup, rail, en, hi95, lo85, ramp, ovt, ovr, th, oc, sst} = 12'h800;
      strap = 5'h00;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      sup = 1'b1;
      rail = 1'b1;
      idle(12);
      t_reset();
      t_strap();
      t_pgood();
      t_faults();
      finish_test();
   end
endmodule
